// File: rtl/dcod_pkg.sv
// Shared constants and types of the driver configuration and OTP default bank
package dcod_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ADDR_OTP_PROG  = 8'h06;
  localparam logic [7:0] ADDR_OTP_READ  = 8'h07;
  localparam logic [7:0] ADDR_CLK_TRIM  = 8'h08;
  localparam logic [7:0] ADDR_SHORT     = 8'h09;
  localparam logic [7:0] ADDR_DRV_STAGE = 8'h0A;
  localparam logic [7:0] ADDR_SCALE     = 8'h0B;
  localparam logic [7:0] ADDR_OFFSET    = 8'h0C;
  localparam logic [7:0] ADDR_BLANK     = 8'h0D;

  // OTP byte bit map
  localparam int OTP_BLANK_BIT = 7;
  localparam int OTP_DEAD_BIT  = 6;
  localparam int OTP_SHORT_BIT = 5;
  localparam int OTP_TRIM_MSB  = 4;
  localparam int OTP_TRIM_LSB  = 0;

  // Power-up defaults selected by OTP bits
  localparam logic [1:0] BLANK_OTP0 = 2'h2;
  localparam logic [1:0] BLANK_OTP1 = 2'h1;
  localparam logic [3:0] DEAD_OTP0  = 4'h4;
  localparam logic [3:0] DEAD_OTP1  = 4'h2;
  localparam logic [3:0] SHORT_OTP0 = 4'h6;
  localparam logic [3:0] SHORT_OTP1 = 4'hC;

  // Driver stage config field positions
  localparam int ANA_LSB  = 0;
  localparam int ANA_MSB  = 4;
  localparam int DIG_LSB  = 8;
  localparam int DIG_MSB  = 11;
  localparam int OT_LSB   = 16;
  localparam int OT_MSB   = 17;
  localparam int GATE_LSB = 18;
  localparam int GATE_MSB = 19;
  localparam int FILT_LSB = 20;
  localparam int FILT_MSB = 21;
  // Short config field positions
  localparam int S2VS_LSB = 0;
  localparam int S2VS_MSB = 3;
  localparam int S2G_LSB  = 8;
  localparam int S2G_MSB  = 11;

  // Reset values of plain fields
  localparam logic [4:0] ANA_RST   = 5'h00;
  localparam logic [1:0] OT_RST    = 2'h0;
  localparam logic [1:0] GATE_RST  = 2'h0;
  localparam logic [1:0] FILT_RST  = 2'h0;
  localparam logic [7:0] SCALE_RST = 8'h00;
  localparam logic [8:0] SCALE_FULL = 9'h100;

  // Overtemperature select and gate drive setting codes
  localparam logic [1:0] OT_SEL_150 = 2'h0;
  localparam logic [1:0] OT_SEL_143 = 2'h1;
  localparam logic [1:0] OT_SEL_136 = 2'h2;
  localparam logic [1:0] GATE_SET_WEAK_TC = 2'h1;
  localparam logic [1:0] GATE_SET_MEDIUM  = 2'h2;

  // Sense filter times and their cycle counts at the core clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_NS_0 = 100;
  localparam int FILT_NS_1 = 200;
  localparam int FILT_NS_2 = 300;
  localparam int FILT_NS_3 = 400;
  localparam int FILT_CYC_0 = (FILT_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC_1 = (FILT_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC_2 = (FILT_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC_3 = (FILT_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {ST_LOAD = 1'b0, ST_RUN = 1'b1} dcod_state_t;
  typedef enum logic [0:0] {DT_IDLE = 1'b0, DT_HOLD = 1'b1} dcod_dead_t;
  typedef enum logic [1:0] {
    GATE_WEAK   = 2'b00,
    GATE_MEDIUM = 2'b01,
    GATE_STRONG = 2'b10
  } dcod_gate_t;
endpackage : dcod_pkg

// File: rtl/dcod_top.sv
// Driver stage configuration bank with OTP power-up defaults
//
// Contract
// - OTP bits start at 0; programming only sets bits, never clears.
// - OTP bit 7 picks blank time default: 0 gives 2, 1 gives 1.
// - OTP bit 6 picks digital dead time default: 0 gives 4, 1 gives 2.
// - OTP bit 5 sets both short levels default: 0 gives 6, 1 gives 12.
// - OTP bits 4..0 give the clock trim power-up value.
// - The OTP byte reads back unchanged at offset 0x07.
// - Dead time lasts 0..15 clocks or the analog delay, whichever longer; the active output stays high for count plus one, 1..16 clocks.
// - Overtemp select picks shutdown level; bridge returns after prewarning clears.
// - Gate drive: weak, weak then medium above prewarning, medium, strong.
// - Sense filter field selects 100, 200, 300 or 400 ns.
// - Global scaler: 0 means full scale, else value in 256ths.
// - Offset register returns phase A in upper, phase B in lower byte.
`timescale 1ns/1ns
module dcod_top #(
  parameter logic [7:0] OTP_INIT = 8'h00,
  parameter int         FILTER_W = 6
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [7:0]  i_offset_a,
  input  wire logic [7:0]  i_offset_b,
  input  wire logic        i_temp_150,
  input  wire logic        i_temp_143,
  input  wire logic        i_temp_136,
  input  wire logic        i_temp_120,
  input  wire logic        i_overtemp_prewarning,
  input  wire logic        i_bridge_switch,
  input  wire logic        i_analog_delay_done,
  output logic [1:0]          o_blank_time,
  output logic [3:0]          o_digital_dead_time_clocks,
  output logic [4:0]          o_analog_dead_time_delay,
  output logic [3:0]          o_short_to_ground_level,
  output logic [3:0]          o_short_to_supply_level,
  output logic [4:0]          o_clock_trim,
  output logic [1:0]          o_overtemp_level_select,
  output logic                o_bridge_disable,
  output logic [1:0]          o_gate_drive_level,
  output logic [FILTER_W-1:0] o_sense_filter_cycles,
  output logic [8:0]          o_current_scale,
  output logic                o_dead_time_active,
  output logic                o_config_ready
);

  // Refuse a filter count too narrow for the longest filter time
  if (FILTER_W < $clog2(dcod_pkg::FILT_CYC_3 + 1)) begin : g_chk
    $error("FILTER_W too small for the sense filter count");
  end

  dcod_pkg::dcod_state_t state_reg;
  dcod_pkg::dcod_dead_t  dt_state_reg;
  logic [7:0]  otp_reg;
  logic [1:0]  blank_reg;
  logic [3:0]  dig_reg;
  logic [4:0]  ana_reg;
  logic [3:0]  s2g_reg;
  logic [3:0]  s2vs_reg;
  logic [4:0]  trim_reg;
  logic [1:0]  ot_reg;
  logic [1:0]  gate_reg;
  logic [1:0]  filt_reg;
  logic [7:0]  scale_reg;
  logic [15:0] offset_reg;
  logic [3:0]  dt_cnt_reg;
  logic        analog_seen_reg;
  logic        bridge_off_reg;
  logic [1:0]          gate_lvl_reg;
  logic [FILTER_W-1:0] filt_cyc_reg;
  logic [8:0]          scale_out_reg;
  logic        dt_active_reg;
  logic [31:0] rdata_reg;

  // Address decode and write qualification
  wire run      = (state_reg == dcod_pkg::ST_RUN);
  wire wr_run   = i_wr && run;
  wire hit_prog = (i_addr == dcod_pkg::ADDR_OTP_PROG);
  wire hit_otp  = (i_addr == dcod_pkg::ADDR_OTP_READ);
  wire hit_trim = (i_addr == dcod_pkg::ADDR_CLK_TRIM);
  wire hit_shrt = (i_addr == dcod_pkg::ADDR_SHORT);
  wire hit_drv  = (i_addr == dcod_pkg::ADDR_DRV_STAGE);
  wire hit_scl  = (i_addr == dcod_pkg::ADDR_SCALE);
  wire hit_off  = (i_addr == dcod_pkg::ADDR_OFFSET);
  wire hit_blk  = (i_addr == dcod_pkg::ADDR_BLANK);

  // OTP derived power-up defaults
  wire [1:0] blank_dflt = otp_reg[dcod_pkg::OTP_BLANK_BIT] ?
                          dcod_pkg::BLANK_OTP1 : dcod_pkg::BLANK_OTP0;
  wire [3:0] dig_dflt   = otp_reg[dcod_pkg::OTP_DEAD_BIT] ?
                          dcod_pkg::DEAD_OTP1 : dcod_pkg::DEAD_OTP0;
  wire [3:0] shrt_dflt  = otp_reg[dcod_pkg::OTP_SHORT_BIT] ?
                          dcod_pkg::SHORT_OTP1 : dcod_pkg::SHORT_OTP0;
  wire [4:0] trim_dflt  = otp_reg[dcod_pkg::OTP_TRIM_MSB:dcod_pkg::OTP_TRIM_LSB];

  // OTP programming can only add ones
  wire [7:0] otp_next = (wr_run && hit_prog) ? (otp_reg | i_wdata[7:0]) : otp_reg;

  // One load cycle after reset, then normal operation
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= dcod_pkg::ST_LOAD;
      otp_reg   <= OTP_INIT;
    end else begin
      state_reg <= dcod_pkg::ST_RUN;
      otp_reg   <= otp_next;
    end
  end

  // Fields that take OTP defaults at load
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      blank_reg <= dcod_pkg::BLANK_OTP0;
      dig_reg   <= dcod_pkg::DEAD_OTP0;
      s2g_reg   <= dcod_pkg::SHORT_OTP0;
      s2vs_reg  <= dcod_pkg::SHORT_OTP0;
      trim_reg  <= 5'h00;
    end else if (!run) begin
      blank_reg <= blank_dflt;
      dig_reg   <= dig_dflt;
      s2g_reg   <= shrt_dflt;
      s2vs_reg  <= shrt_dflt;
      trim_reg  <= trim_dflt;
    end else if (i_wr) begin
      if (hit_blk) blank_reg <= i_wdata[1:0];
      if (hit_drv) dig_reg <= i_wdata[dcod_pkg::DIG_MSB:dcod_pkg::DIG_LSB];
      if (hit_shrt) s2g_reg <= i_wdata[dcod_pkg::S2G_MSB:dcod_pkg::S2G_LSB];
      if (hit_shrt) s2vs_reg <= i_wdata[dcod_pkg::S2VS_MSB:dcod_pkg::S2VS_LSB];
      if (hit_trim) trim_reg <= i_wdata[4:0];
    end
  end

  // Plain write-only fields with fixed resets
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ana_reg   <= dcod_pkg::ANA_RST;
      ot_reg    <= dcod_pkg::OT_RST;
      gate_reg  <= dcod_pkg::GATE_RST;
      filt_reg  <= dcod_pkg::FILT_RST;
      scale_reg <= dcod_pkg::SCALE_RST;
    end else if (wr_run && hit_drv) begin
      ana_reg  <= i_wdata[dcod_pkg::ANA_MSB:dcod_pkg::ANA_LSB];
      ot_reg   <= i_wdata[dcod_pkg::OT_MSB:dcod_pkg::OT_LSB];
      gate_reg <= i_wdata[dcod_pkg::GATE_MSB:dcod_pkg::GATE_LSB];
      filt_reg <= i_wdata[dcod_pkg::FILT_MSB:dcod_pkg::FILT_LSB];
    end else if (wr_run && hit_scl) begin
      scale_reg <= i_wdata[7:0];
    end
  end

  // Selected overtemperature comparator
  wire ot_hit = (ot_reg == dcod_pkg::OT_SEL_150) ? i_temp_150 :
                (ot_reg == dcod_pkg::OT_SEL_143) ? i_temp_143 :
                (ot_reg == dcod_pkg::OT_SEL_136) ? i_temp_136 : i_temp_120;
  // Trip sets, release only once cooled below prewarning
  wire bridge_next = ot_hit ? 1'b1 :
                     (!i_overtemp_prewarning ? 1'b0 : bridge_off_reg);

  // Gate drive decode; weak+TC steps up above prewarning
  wire [1:0] gate_next =
    (gate_reg == dcod_pkg::GATE_SET_WEAK_TC) ?
      (i_overtemp_prewarning ? dcod_pkg::GATE_MEDIUM : dcod_pkg::GATE_WEAK) :
    (gate_reg == dcod_pkg::GATE_SET_MEDIUM) ? dcod_pkg::GATE_MEDIUM :
    (gate_reg == dcod_pkg::GATE_RST) ? dcod_pkg::GATE_WEAK :
    dcod_pkg::GATE_STRONG;

  // Sense filter time in core clock cycles
  wire [FILTER_W-1:0] filt_next =
    (filt_reg == 2'h0) ? FILTER_W'(dcod_pkg::FILT_CYC_0) :
    (filt_reg == 2'h1) ? FILTER_W'(dcod_pkg::FILT_CYC_1) :
    (filt_reg == 2'h2) ? FILTER_W'(dcod_pkg::FILT_CYC_2) :
    FILTER_W'(dcod_pkg::FILT_CYC_3);

  // Zero scaler means full scale
  wire [8:0] scale_next = (scale_reg == dcod_pkg::SCALE_RST) ?
                          dcod_pkg::SCALE_FULL : {1'b0, scale_reg};

  // Decoded stage controls, registered for clean outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bridge_off_reg <= 1'b0;
      gate_lvl_reg   <= dcod_pkg::GATE_WEAK;
      filt_cyc_reg   <= FILTER_W'(dcod_pkg::FILT_CYC_0);
      scale_out_reg  <= dcod_pkg::SCALE_FULL;
      offset_reg     <= 16'h0000;
    end else begin
      bridge_off_reg <= bridge_next;
      gate_lvl_reg   <= gate_next;
      filt_cyc_reg   <= filt_next;
      scale_out_reg  <= scale_next;
      offset_reg     <= {i_offset_a, i_offset_b};
    end
  end

  // Dead time: digital count and analog delay must both expire
  wire analog_ok = analog_seen_reg || i_analog_delay_done;
  wire dt_start  = (dt_state_reg == dcod_pkg::DT_IDLE) && i_bridge_switch && run;
  wire dt_done   = (dt_state_reg == dcod_pkg::DT_HOLD) && (dt_cnt_reg == 4'h0) &&
                   analog_ok;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dt_state_reg    <= dcod_pkg::DT_IDLE;
      dt_cnt_reg      <= 4'h0;
      analog_seen_reg <= 1'b0;
      dt_active_reg   <= 1'b0;
    end else begin
      case (dt_state_reg)
        dcod_pkg::DT_IDLE: begin
          if (dt_start) begin
            dt_state_reg    <= dcod_pkg::DT_HOLD;
            dt_cnt_reg      <= dig_reg;
            analog_seen_reg <= 1'b0;
            dt_active_reg   <= 1'b1;
          end
        end
        dcod_pkg::DT_HOLD: begin
          if (dt_done) begin
            dt_state_reg  <= dcod_pkg::DT_IDLE;
            dt_active_reg <= 1'b0;
          end else begin
            if (dt_cnt_reg != 4'h0) dt_cnt_reg <= dt_cnt_reg - 4'h1;
            if (i_analog_delay_done) analog_seen_reg <= 1'b1;
          end
        end
        default: dt_state_reg <= dcod_pkg::DT_IDLE;
      endcase
    end
  end

  // Read mux; write-only and unmapped offsets read as zero
  wire [31:0] rd_sel =
    hit_otp  ? {24'h000000, otp_reg} :
    hit_trim ? {27'h0, trim_reg} :
    hit_off  ? {16'h0000, offset_reg} : 32'h00000000;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= i_rd ? rd_sel : 32'h00000000;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata                    = rdata_reg;
  assign o_blank_time               = blank_reg;
  assign o_digital_dead_time_clocks = dig_reg;
  assign o_analog_dead_time_delay   = ana_reg;
  assign o_short_to_ground_level    = s2g_reg;
  assign o_short_to_supply_level    = s2vs_reg;
  assign o_clock_trim               = trim_reg;
  assign o_overtemp_level_select    = ot_reg;
  assign o_bridge_disable           = bridge_off_reg;
  assign o_gate_drive_level         = gate_lvl_reg;
  assign o_sense_filter_cycles      = filt_cyc_reg;
  assign o_current_scale            = scale_out_reg;
  assign o_dead_time_active         = dt_active_reg;
  assign o_config_ready             = state_reg;

  // Checks on the logic above
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_load;
    state_reg == dcod_pkg::ST_LOAD;
  endsequence

  a_otp_no_clear: assert property (
    ##1 (($past(otp_reg) & ~otp_reg) == 8'h00))
    else $error("OTP bit cleared");
  a_blank_default: assert property (
    s_load |=> o_blank_time == ($past(otp_reg[dcod_pkg::OTP_BLANK_BIT]) ?
                                dcod_pkg::BLANK_OTP1 : dcod_pkg::BLANK_OTP0))
    else $error("blank time default wrong");
  a_dead_default: assert property (
    s_load |=> o_digital_dead_time_clocks == ($past(otp_reg[dcod_pkg::OTP_DEAD_BIT]) ?
                                dcod_pkg::DEAD_OTP1 : dcod_pkg::DEAD_OTP0))
    else $error("dead time default wrong");
  a_short_default: assert property (
    s_load |=> (o_short_to_ground_level == o_short_to_supply_level) &&
      o_short_to_ground_level == ($past(otp_reg[dcod_pkg::OTP_SHORT_BIT]) ?
                                  dcod_pkg::SHORT_OTP1 : dcod_pkg::SHORT_OTP0))
    else $error("short level default wrong");
  a_trim_default: assert property (
    s_load |=> o_clock_trim == $past(otp_reg[4:0]) ##1 o_config_ready)
    else $error("clock trim default wrong");
  a_otp_readback: assert property (
    i_rd && hit_otp |=> o_rdata == {24'h000000, $past(otp_reg)} ##1
                        (o_rdata == 32'h0 || $past(i_rd)))
    else $error("OTP readback wrong");
  a_dead_analog: assert property (
    dt_state_reg == dcod_pkg::DT_HOLD && !analog_ok |=> o_dead_time_active)
    else $error("dead time ended before analog delay");
  a_dead_digital: assert property (
    dt_start && dig_reg == 4'h3 |=> o_dead_time_active [*4])
    else $error("dead time shorter than digital count");
  a_bridge_trip: assert property (
    ot_hit |=> o_bridge_disable and (i_overtemp_prewarning |=> o_bridge_disable))
    else $error("bridge not held off");
  a_gate_boost: assert property (
    gate_reg == dcod_pkg::GATE_SET_WEAK_TC && i_overtemp_prewarning
      |=> o_gate_drive_level == dcod_pkg::GATE_MEDIUM)
    else $error("gate drive not boosted");
  a_filter_long: assert property (
    filt_reg == 2'h3 |=> o_sense_filter_cycles == FILTER_W'(dcod_pkg::FILT_CYC_3))
    else $error("filter time wrong");
  a_scale_full: assert property (
    wr_run && hit_scl && i_wdata[7:0] == 8'h00 |=> ##1 o_current_scale == 9'h100)
    else $error("zero scaler not full scale");
  a_offset_read: assert property (
    i_rd && hit_off |=> o_rdata[15:8] == $past(offset_reg[15:8]) &&
                        o_rdata[7:0] == $past(offset_reg[7:0]))
    else $error("offset read wrong");

endmodule : dcod_top

// File: tb/tb_top.sv
// Self-checking testbench for the driver configuration and OTP default bank
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] OTP_A = 8'hE5;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_offset_a = 8'h9C;
  logic [7:0]  i_offset_b = 8'h35;
  logic [3:0]  temps = 4'h0;
  logic        i_overtemp_prewarning = 1'b0;
  logic        i_bridge_switch = 1'b0;
  logic        i_analog_delay_done = 1'b0;
  logic [31:0] o_rdata, rdata0, rd_a, rd_b;
  logic [1:0]  o_blank_time, blank0, o_ot, o_gate;
  logic [3:0]  o_dead, dead0, o_s2g, o_s2vs, s2g0, s2vs0;
  logic [4:0]  o_ana, o_trim, trim0;
  logic [5:0]  o_filt;
  logic [8:0]  o_scale;
  logic        o_bridge_disable, o_dt_active, o_config_ready;
  int          n_fail = 0;
  int          cmp_count = 0;

  // Free-running core clock, 10 ns period
  always #5 i_clk = ~i_clk;

  // Device with a programmed OTP byte
  dcod_top #(.OTP_INIT(OTP_A), .FILTER_W(6)) uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_offset_a(i_offset_a), .i_offset_b(i_offset_b),
    .i_temp_150(temps[0]), .i_temp_143(temps[1]), .i_temp_136(temps[2]),
    .i_temp_120(temps[3]), .i_overtemp_prewarning(i_overtemp_prewarning),
    .i_bridge_switch(i_bridge_switch), .i_analog_delay_done(i_analog_delay_done),
    .o_blank_time(o_blank_time), .o_digital_dead_time_clocks(o_dead),
    .o_analog_dead_time_delay(o_ana), .o_short_to_ground_level(o_s2g),
    .o_short_to_supply_level(o_s2vs), .o_clock_trim(o_trim), .o_overtemp_level_select(o_ot),
    .o_bridge_disable(o_bridge_disable), .o_gate_drive_level(o_gate),
    .o_sense_filter_cycles(o_filt), .o_current_scale(o_scale),
    .o_dead_time_active(o_dt_active), .o_config_ready(o_config_ready));

  // Blank OTP device, judged on its defaults and on OTP programming
  dcod_top #(.OTP_INIT(8'h00), .FILTER_W(6)) uut_blank (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata0), .i_offset_a(i_offset_a), .i_offset_b(i_offset_b),
    .i_temp_150(temps[0]), .i_temp_143(temps[1]), .i_temp_136(temps[2]),
    .i_temp_120(temps[3]), .i_overtemp_prewarning(i_overtemp_prewarning),
    .i_bridge_switch(i_bridge_switch), .i_analog_delay_done(i_analog_delay_done),
    .o_blank_time(blank0), .o_digital_dead_time_clocks(dead0), .o_analog_dead_time_delay(),
    .o_short_to_ground_level(s2g0), .o_short_to_supply_level(s2vs0), .o_clock_trim(trim0),
    .o_overtemp_level_select(), .o_bridge_disable(), .o_gate_drive_level(),
    .o_sense_filter_cycles(), .o_current_scale(), .o_dead_time_active(),
    .o_config_ready());

  // Compare and count, report a mismatch at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr_reg

  // One-cycle register read, data taken in the following cycle from both devices
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_a = o_rdata;
    rd_b = rdata0;
  endtask : rd_reg

  // Driver stage word built from its fields
  task automatic wr_drv(input logic [4:0] ana, input logic [3:0] dig, input logic [1:0] ot,
                        input logic [1:0] gate, input logic [1:0] filt);
    wr_reg(8'h0A, {10'h0, filt, gate, ot, 4'h0, dig, 3'h0, ana});
  endtask : wr_drv

  // Let registered and derived outputs settle
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle

  // Power-up defaults from both OTP images and readback of the byte
  task automatic t_defaults;
    chk("ready", 32'h1, o_config_ready);
    chk("blank", 32'h1, o_blank_time);
    chk("blank0", 32'h2, blank0);
    chk("dead", 32'h2, o_dead);
    chk("dead0", 32'h4, dead0);
    chk("s2g", 32'hC, o_s2g);
    chk("s2vs", 32'hC, o_s2vs);
    chk("s2g0", 32'h6, s2g0);
    chk("s2vs0", 32'h6, s2vs0);
    chk("trim", 32'h5, o_trim);
    chk("trim0", 32'h0, trim0);
    rd_reg(8'h07);
    chk("otp", 32'hE5, rd_a);
    chk("otp0", 32'h0, rd_b);
    settle(1);
    chk("rdata idle", 32'h0, o_rdata);
    rd_reg(8'h08);
    chk("trim read", 32'h5, rd_a);
  endtask : t_defaults

  // Programming only sets bits, trim bits left alone; the readback place ignores writes
  task automatic t_otp_prog;
    wr_reg(8'h06, 32'h40);
    rd_reg(8'h07);
    chk("otp set", 32'hE5, rd_a);
    chk("otp0 set", 32'h40, rd_b);
    wr_reg(8'h06, 32'h00);
    wr_reg(8'h07, 32'h00);
    rd_reg(8'h07);
    chk("otp kept", 32'hE5, rd_a);
    chk("otp0 kept", 32'h40, rd_b);
  endtask : t_otp_prog

  // Short levels and blank time take written values after power-up
  task automatic t_fields;
    wr_reg(8'h09, 32'h0907);
    wr_reg(8'h0D, 32'h3);
    settle(1);
    chk("s2g wr", 32'h9, o_s2g);
    chk("s2vs wr", 32'h7, o_s2vs);
    chk("blank wr", 32'h3, o_blank_time);
  endtask : t_fields

  // Offset result layout, read-only and unmapped places
  task automatic t_offsets;
    wr_reg(8'h0C, 32'h0);
    rd_reg(8'h0C);
    chk("offset", 32'h9C35, rd_a);
    rd_reg(8'h0E);
    chk("unmapped", 32'h0, rd_a);
    rd_reg(8'h0B);
    chk("wo read", 32'h0, rd_a);
  endtask : t_offsets

  // Global scaler, zero meaning full scale; operating values kept out of 1..31
  task automatic t_scale;
    logic [7:0] v [4] = '{8'h00, 8'h20, 8'h80, 8'hFF};
    logic [8:0] e [4] = '{9'h100, 9'h020, 9'h080, 9'h0FF};
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h0B, {24'h0, v[k]});
      settle(1);
      chk("scale", e[k], o_scale);
    end
  endtask : t_scale

  // Every code of the select, drive and filter fields
  task automatic t_drv;
    logic [1:0] g_lo [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [1:0] g_hi [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    for (int k = 0; k < 4; k++) begin
      wr_drv(5'h11 + 5'(k), 4'h3, 2'(k), 2'(k), 2'(k));
      settle(1);
      chk("analog", 32'h11 + k, o_ana);
      chk("ot sel", k, o_ot);
      chk("filter", 10 * (k + 1), o_filt);
      chk("gate lo", g_lo[k], o_gate);
      i_overtemp_prewarning <= 1'b1;
      settle(2);
      chk("gate hi", g_hi[k], o_gate);
      i_overtemp_prewarning <= 1'b0;
      settle(2);
    end
  endtask : t_drv

  // Shutdown at the selected level only, return after prewarning clears
  task automatic t_overtemp;
    for (int k = 0; k < 4; k++) begin
      wr_drv(5'h00, 4'h4, 2'(k), 2'h0, 2'h0);
      settle(1);
      if (k < 3) begin
        temps <= 4'(1 << (k + 1));
        settle(2);
        chk("cooler level", 32'h0, o_bridge_disable);
      end
      temps <= 4'(1 << k);
      i_overtemp_prewarning <= 1'b1;
      settle(2);
      chk("shutdown", 32'h1, o_bridge_disable);
      temps <= 4'h0;
      settle(2);
      chk("still warm", 32'h1, o_bridge_disable);
      i_overtemp_prewarning <= 1'b0;
      settle(2);
      chk("re-enable", 32'h0, o_bridge_disable);
    end
  endtask : t_overtemp

  // Dead time length from the digital count, then held by a slow analog delay
  task automatic t_dead;
    logic [3:0] n [3] = '{4'h0, 4'h3, 4'hF};
    int cnt;
    for (int k = 0; k < 3; k++) begin
      wr_drv(5'h00, n[k], 2'h0, 2'h0, 2'h0);
      i_analog_delay_done <= 1'b1;
      @(posedge i_clk);
      i_bridge_switch <= 1'b1;
      @(posedge i_clk);
      i_bridge_switch <= 1'b0;
      cnt = 0;
      repeat (40) begin
        #1;
        if (o_dt_active === 1'b1) cnt++;
        @(posedge i_clk);
      end
      chk("dead len", n[k] + 1, cnt);
    end
    wr_drv(5'h00, 4'h0, 2'h0, 2'h0, 2'h0);
    i_analog_delay_done <= 1'b0;
    @(posedge i_clk);
    i_bridge_switch <= 1'b1;
    @(posedge i_clk);
    i_bridge_switch <= 1'b0;
    settle(6);
    chk("analog hold", 32'h1, o_dt_active);
    i_analog_delay_done <= 1'b1;
    settle(4);
    chk("analog end", 32'h0, o_dt_active);
  endtask : t_dead

  // Verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (20) if (o_config_ready !== 1'b1) @(posedge i_clk);
    settle(1);
    t_defaults();
    t_otp_prog();
    t_offsets();
    t_fields();
    t_scale();
    t_drv();
    t_overtemp();
    t_dead();
    conclude();
  end
endmodule : tb_top
